// [common/slave_cmd_pkg.sv]
// constants of the slave command handler
// assumes bytes arrive deframed, CRC checked upstream
package slave_cmd_pkg;
	// ==========
	// clock and timing
	localparam int CLK_HZ   = 50_000_000;
	localparam int GAP_BITS = 24;
	// ==========
	// register addresses
	localparam logic [15:0] ADDR_OP         = 16'h0001;
	localparam logic [15:0] ADDR_REF        = 16'h0002;
	localparam logic [15:0] ADDR_MON_LO     = 16'h0020;
	localparam logic [15:0] ADDR_MON_HI     = 16'h003F;
	localparam logic [15:0] ADDR_PARAM_BASE = 16'h0100;
	localparam logic [15:0] ADDR_COMMIT_NVM = 16'h0900;
	localparam logic [15:0] ADDR_COMMIT_RAM = 16'h0910;
	localparam logic [15:0] COMMIT_VALUE    = 16'h0000;
	// ==========
	// function and exception codes
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] FC_READ    = 8'h03;
	localparam logic [7:0] FC_LOOP    = 8'h08;
	localparam logic [7:0] FC_WRITE   = 8'h10;
	localparam logic [7:0] EXC_FLAG   = 8'h80;
	localparam logic [7:0] EXC_NONE   = 8'h00;
	localparam logic [7:0] EXC_FUNC   = 8'h01;
	localparam logic [7:0] EXC_REG    = 8'h02;
	localparam logic [7:0] EXC_QTY    = 8'h03;
	localparam logic [7:0] EXC_DATA   = 8'h21;
	localparam logic [7:0] EXC_MODE   = 8'h22;
	localparam logic [7:0] EXC_UV     = 8'h23;
	localparam logic [7:0] EXC_BUSY   = 8'h24;
	// ==========
	// frame layout and limits
	localparam logic [15:0] QTY_MAX  = 16'h0010;
	localparam int          BUF_AW   = 4;
	localparam logic [5:0]  HDR_LEN  = 6'h06;
	localparam logic [5:0]  DATA_POS = 6'h07;
	localparam logic [5:0]  EXC_LEN  = 6'h03;
	localparam logic [15:0] SPEED_FULL = 16'h7530;
	// ==========
	// operation word fields
	localparam int          OPB_RUN  = 0;
	localparam int          OPB_REV  = 1;
	localparam int          OPB_EXTF = 4;
	localparam int          OPB_FRST = 5;
	localparam int          OPB_DI   = 12;
	localparam logic [15:0] LOCAL_MASK = 16'h0FCC;
	// ==========
	// self test
	localparam logic [7:0] TEST_MODE_CODE = 8'h43;
	localparam logic [7:0] ST_PATTERN     = 8'h55;
endpackage

// [common/cmd_links_if.sv]
// carriers between the command handler and its memory and self test helpers
// assumes a single clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface store_if #(parameter int AW = 4);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [15:0]   wr_data;
	logic [AW-1:0] rd_addr;
	logic [15:0]   rd_data;
	modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

interface test_link_if;
	logic       req;
	logic [7:0] byte_out;
	logic       ack;
	logic       rx_valid;
	logic [7:0] rx_byte;
	logic       pass;
	logic       fail;
	modport tester (output req, byte_out, pass, fail, input ack, rx_valid, rx_byte);
	modport host   (input req, byte_out, pass, fail, output ack, rx_valid, rx_byte);
endinterface
`default_nettype wire

// [rtl/word_store.sv]
// small word memory, one write port, one registered read port
// assumes the user holds rd_addr one cycle ahead of needing rd_data
`timescale 1ns/100ps
`default_nettype none
module word_store #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input wire logic clk,
	store_if.mem     port
);
	logic [15:0] cells [DEPTH];

	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
		$error("word_store depth does not fit address width");
	end

	// contents carry no reset; words never written read back as unknown
	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			cells[port.wr_addr] <= port.wr_data;
		end
		port.rd_data <= cells[port.rd_addr];
	end
endmodule
`default_nettype wire

// [rtl/loop_selftest.sv]
// loopback self test: sends a byte pattern and compares what comes back
// assumes transmit and receive are wired together outside while enabled
`timescale 1ns/100ps
`default_nettype none
module loop_selftest import slave_cmd_pkg::*; #(
	parameter int PATTERN_LEN = 4,
	parameter int TIMEOUT     = 4000
) (
	input wire logic   clk,
	input wire logic   sys_rst,
	input wire logic   enable,
	test_link_if.tester link
);
	localparam int TW = $clog2(TIMEOUT + 1);
	localparam int KW = $clog2(PATTERN_LEN + 1);

	typedef enum logic [1:0] {T_IDLE, T_SEND, T_WAIT, T_DONE} tstate_e;

	tstate_e       state;
	logic [KW-1:0] k;
	logic [TW-1:0] timer;
	logic [7:0]    expect_b;

	if (PATTERN_LEN < 1 || TIMEOUT < 1) begin : g_chk
		$error("loop_selftest needs a pattern and a timeout");
	end

	assign expect_b      = ST_PATTERN ^ 8'(k);
	assign link.byte_out = expect_b;

	// ==========
	// sequencing
	// verdict stays latched until the mode is left and entered again
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= T_IDLE;
			k         <= '0;
			timer     <= '0;
			link.req  <= 1'b0;
			link.pass <= 1'b0;
			link.fail <= 1'b0;
		end else if (!enable) begin
			state    <= T_IDLE;
			link.req <= 1'b0;
		end else begin
			unique case (state)
				T_IDLE: begin
					k         <= '0;
					link.pass <= 1'b0;
					link.fail <= 1'b0;
					link.req  <= 1'b1;
					state     <= T_SEND;
				end
				T_SEND: if (link.ack) begin
					link.req <= 1'b0;
					timer    <= '0;
					state    <= T_WAIT;
				end
				T_WAIT: if (link.rx_valid) begin
					if (link.rx_byte != expect_b) begin
						link.fail <= 1'b1;
						state     <= T_DONE;
					end else if (k == KW'(PATTERN_LEN - 1)) begin
						link.pass <= 1'b1;
						state     <= T_DONE;
					end else begin
						k        <= k + 1'b1;
						link.req <= 1'b1;
						state    <= T_SEND;
					end
				end else if (timer == TW'(TIMEOUT)) begin
					link.fail <= 1'b1;
					state     <= T_DONE;
				end else begin
					timer <= timer + 1'b1;
				end
				T_DONE: begin
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [rtl/slave_cmd_handler.sv]
// serial slave command handler: frame checks, broadcast data, staged
// parameters with commit, exception replies and loopback self test.
// assumes a deframer on clk delivering bytes without CRC, and a
// transmitter that appends CRC and takes bytes on tx_valid and tx_ready.
// Notes on behaviour
// - op word bit0 run, bit1 reverse
// - bit4 external fault, bit5 fault reset
// - bits 12..15 drive digital inputs five..eight
// - undefined op bits follow local node data
// - parameter writes staged until commit
// - zero to persistent commit: activate and store
// - zero to volatile commit: activate only
// - reading commit registers gives code 02
// - unknown function code gives code 01
// - missing register or bad broadcast start: 02
// - register count outside 1..16 gives 03
// - byte count not twice count gives 03
// - out of limit data gives code 21
// - parameter write or commit while running: 22
// - read-only or nvm defect restricted write: 22
// - parameter write or commit under undervoltage: 23
// - parameter write while busy gives 24
// - line errors, foreign address, bad length: silent
// - broadcast address zero executes, never replies
// - inter-byte gap over 24 bits: silent
// - loopback test: pass, or alarm and not ready
`timescale 1ns/100ps
`default_nettype none
module slave_cmd_handler import slave_cmd_pkg::*; #(
	parameter logic [7:0]  DEVICE_ADDR    = 8'h01,
	parameter int          BAUD           = 9600,
	parameter int          GAP_CYCLES     = CLK_HZ / BAUD * GAP_BITS,
	parameter int          PARAM_COUNT    = 16,
	parameter int          NVM_FREE_COUNT = 2,
	parameter logic [15:0] PARAM_LIMIT    = 16'h7FFF,
	parameter logic [15:0] FMAX_UNITS     = 16'h1770,
	parameter int          ST_TIMEOUT     = 4000
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          rx_valid,
	input  wire logic [7:0]                    rx_byte,
	input  wire logic                          rx_end,
	input  wire logic                          rx_err,
	input  wire logic                          tx_ready,
	input  wire logic                          motor_running,
	input  wire logic                          undervoltage_alarm,
	input  wire logic                          nvm_defect_alarm,
	input  wire logic                          proc_busy,
	input  wire logic                          nvm_done,
	input  wire logic [15:0]                   local_op,
	input  wire logic [7:0]                    input_function_select_fifth,
	input  wire logic [$clog2(PARAM_COUNT)-1:0] param_rd_addr,
	output logic                               tx_valid,
	output logic [7:0]                         tx_data,
	output logic                               tx_last,
	output logic [15:0]                        op_word,
	output logic                               run_cmd,
	output logic                               reverse_cmd,
	output logic                               ext_fault,
	output logic                               fault_reset,
	output logic                               digital_input_five,
	output logic                               digital_input_six,
	output logic                               digital_input_seven,
	output logic                               digital_input_eight,
	output logic [15:0]                        speed_ref,
	output logic [15:0]                        freq_out,
	output logic [15:0]                        param_rd_data,
	output logic                               nvm_write_req,
	output logic                               test_pass,
	output logic                               comm_error_alarm,
	output logic                               error_contact,
	output logic                               op_ready
);
	localparam int AW = $clog2(PARAM_COUNT);
	localparam int GW = $clog2(GAP_CYCLES + 1);

	if (PARAM_COUNT < 2 || NVM_FREE_COUNT > PARAM_COUNT || GAP_CYCLES < 1
			|| 32'(ADDR_PARAM_BASE) + PARAM_COUNT > 32'(ADDR_COMMIT_NVM)) begin : g_chk
		$error("slave_cmd_handler parameters out of range");
	end

	typedef enum logic [2:0] {S_IDLE, S_RECV, S_CHECK, S_WRITE, S_READ, S_COMMIT, S_RESP} state_e;

	state_e        state;
	logic [5:0]    rx_n;
	logic [7:0]    r_slave, r_func, r_bc, hi_b;
	logic [15:0]   r_a, r_q, op_raw, hold_w;
	logic          bad, over, data_err, resp_exc, nvm_sel, nvm_pending, test_mode;
	logic [7:0]    exc_code;
	logic [GW-1:0] gap_cnt;
	logic [5:0]    cnt, cnt_d, tx_idx, resp_len;
	logic          pend, fetched;
	logic [16:0]   e_addr;
	logic          in_bc, in_par, in_mon, is_commit, bcast, len_ok, silent, qty_bad;
	logic [7:0]    exc, resp_byte;
	logic [4:0]    widx;
	logic [15:0]   t_iss, t_wr, dword, copy_n;
	logic [5:0]    didx;

	store_if #(.AW(BUF_AW)) buf_if ();
	store_if #(.AW(AW))     stg_if ();
	store_if #(.AW(AW))     act_if ();
	test_link_if            st_if ();

	word_store #(.DEPTH(1 << BUF_AW), .AW(BUF_AW)) u_rxbuf (.clk(clk), .port(buf_if));
	word_store #(.DEPTH(PARAM_COUNT), .AW(AW))     u_stage (.clk(clk), .port(stg_if));
	word_store #(.DEPTH(PARAM_COUNT), .AW(AW))     u_active (.clk(clk), .port(act_if));
	loop_selftest #(.TIMEOUT(ST_TIMEOUT)) u_selftest (
		.clk     (clk),
		.sys_rst (sys_rst),
		.enable  (test_mode),
		.link    (st_if)
	);

	function automatic logic is_param(input logic [15:0] x);
		return x >= ADDR_PARAM_BASE && 32'(x) < 32'(ADDR_PARAM_BASE) + PARAM_COUNT;
	endfunction

	// ==========
	// request decode
	always_comb begin
		e_addr    = 17'(r_a) + 17'(r_q) - 17'h00001;
		in_bc     = e_addr <= 17'(ADDR_REF);
		in_par    = is_param(r_a) && is_param(e_addr[15:0]) && !e_addr[16];
		in_mon    = r_a >= ADDR_MON_LO && e_addr <= 17'(ADDR_MON_HI);
		is_commit = (r_a == ADDR_COMMIT_NVM || r_a == ADDR_COMMIT_RAM) && r_q == 16'h0001;
		bcast     = r_slave == BCAST_ADDR;
		qty_bad   = r_q == 16'h0000 || r_q > QTY_MAX;
		case (r_func)
			FC_READ, FC_LOOP: len_ok = rx_n == HDR_LEN;
			FC_WRITE:         len_ok = 9'(rx_n) == 9'(DATA_POS) + 9'(r_bc);
			default:          len_ok = rx_n >= 6'h02;
		endcase
		silent = bad || over || !len_ok || (!bcast && r_slave != DEVICE_ADDR);
		exc = EXC_NONE;
		if (r_func != FC_READ && r_func != FC_WRITE && r_func != FC_LOOP) begin
			exc = EXC_FUNC;
		end else if (r_func == FC_READ) begin
			if (qty_bad) begin
				exc = EXC_QTY;
			end else if (!(in_bc || in_par || in_mon)) begin
				exc = EXC_REG;
			end
		end else if (r_func == FC_WRITE) begin
			if (qty_bad || {8'h00, r_bc} != {r_q[14:0], 1'b0}) begin
				exc = EXC_QTY;
			end else if (bcast && r_a > ADDR_REF) begin
				exc = EXC_REG;
			end else if (in_mon) begin
				exc = EXC_MODE;
			end else if (!(in_bc || in_par || is_commit)) begin
				exc = EXC_REG;
			end else if ((in_par || is_commit) && motor_running) begin
				exc = EXC_MODE;
			end else if (in_par && nvm_defect_alarm
					&& 32'(e_addr) >= 32'(ADDR_PARAM_BASE) + NVM_FREE_COUNT) begin
				exc = EXC_MODE;
			end else if ((in_par || is_commit) && undervoltage_alarm) begin
				exc = EXC_UV;
			end else if ((in_par || is_commit) && (proc_busy || nvm_pending)) begin
				exc = EXC_BUSY;
			end else if (data_err) begin
				exc = EXC_DATA;
			end
		end
	end

	// ==========
	// buffer and parameter memory steering
	always_comb begin
		widx   = 5'(rx_n - DATA_POS - 6'h01) >> 1;
		dword  = {hi_b, rx_byte};
		t_iss  = r_a + 16'(cnt);
		t_wr   = r_a + 16'(cnt_d);
		copy_n = (state == S_COMMIT) ? 16'(PARAM_COUNT) : r_q;
		didx   = tx_idx - EXC_LEN;
		buf_if.wr_en   = (state == S_RECV && rx_valid && rx_n > DATA_POS && !rx_n[0]
				&& !widx[4]) || (state == S_READ && pend);
		buf_if.wr_addr = (state == S_READ) ? BUF_AW'(cnt_d) : widx[BUF_AW-1:0];
		buf_if.wr_data = (state == S_READ) ? (in_par ? stg_if.rd_data : hold_w) : dword;
		buf_if.rd_addr = (state == S_RESP) ? BUF_AW'(didx >> 1) : BUF_AW'(cnt);
		stg_if.wr_en   = state == S_WRITE && pend && is_param(t_wr);
		stg_if.wr_addr = AW'(t_wr - ADDR_PARAM_BASE);
		stg_if.wr_data = buf_if.rd_data;
		stg_if.rd_addr = (state == S_COMMIT) ? AW'(cnt) : AW'(t_iss - ADDR_PARAM_BASE);
		act_if.wr_en   = state == S_COMMIT && pend;
		act_if.wr_addr = AW'(cnt_d);
		act_if.wr_data = stg_if.rd_data;
		act_if.rd_addr = param_rd_addr;
	end

	// ==========
	// reply bytes
	always_comb begin
		resp_len  = resp_exc ? EXC_LEN : (r_func == FC_READ) ? EXC_LEN + {r_q[4:0], 1'b0} : HDR_LEN;
		resp_byte = DEVICE_ADDR;
		if (tx_idx == 6'h01) begin
			resp_byte = resp_exc ? (r_func | EXC_FLAG) : r_func;
		end else if (resp_exc && tx_idx == 6'h02) begin
			resp_byte = exc_code;
		end else if (r_func == FC_READ && tx_idx == 6'h02) begin
			resp_byte = {r_q[6:0], 1'b0};
		end else if (r_func == FC_READ && tx_idx > 6'h02) begin
			resp_byte = didx[0] ? buf_if.rd_data[7:0] : buf_if.rd_data[15:8];
		end else if (tx_idx != 6'h00) begin
			unique case (tx_idx[1:0])
				2'h2:    resp_byte = r_a[15:8];
				2'h3:    resp_byte = r_a[7:0];
				2'h0:    resp_byte = r_q[15:8];
				default: resp_byte = r_q[7:0];
			endcase
		end
	end

	// ==========
	// receive and sequencing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_IDLE;
			rx_n <= '0;
			{r_slave, r_func, r_bc, hi_b} <= '0;
			{r_a, r_q} <= '0;
			{bad, over, data_err, resp_exc, nvm_sel, pend} <= '0;
			exc_code <= EXC_NONE;
			gap_cnt <= '0;
			{cnt, cnt_d} <= '0;
		end else begin
			unique case (state)
				S_IDLE: if (rx_valid && !test_mode) begin
					r_slave <= rx_byte;
					rx_n <= 6'h01;
					{bad, over, data_err} <= {rx_err, 2'b00};
					gap_cnt <= '0;
					state <= S_RECV;
				end
				S_RECV: begin
					if (rx_valid) begin
						gap_cnt <= '0;
						if (gap_cnt == GW'(GAP_CYCLES) || rx_err) begin
							bad <= 1'b1;
						end
						if (rx_n == 6'h3F) begin
							over <= 1'b1;
						end else begin
							rx_n <= rx_n + 6'h01;
						end
						unique case (rx_n)
							6'h01: r_func <= rx_byte;
							6'h02: r_a[15:8] <= rx_byte;
							6'h03: r_a[7:0] <= rx_byte;
							6'h04: r_q[15:8] <= rx_byte;
							6'h05: r_q[7:0] <= rx_byte;
							6'h06: r_bc <= rx_byte;
							default: hi_b <= rx_byte;
						endcase
						if (rx_n > DATA_POS && !rx_n[0]) begin
							if (widx[4]) begin
								over <= 1'b1;
							end
							if ((r_a + 16'(widx) == ADDR_REF && dword > SPEED_FULL)
									|| (is_param(r_a + 16'(widx)) && dword > PARAM_LIMIT)
									|| (is_commit && dword != COMMIT_VALUE)) begin
								data_err <= 1'b1;
							end
						end
					end else if (gap_cnt != GW'(GAP_CYCLES)) begin
						gap_cnt <= gap_cnt + 1'b1;
					end
					if (rx_err) begin
						bad <= 1'b1;
					end
					if (rx_end) begin
						state <= S_CHECK;
					end
				end
				S_CHECK: begin
					{cnt, pend} <= '0;
					exc_code <= exc;
					resp_exc <= exc != EXC_NONE;
					nvm_sel <= r_a == ADDR_COMMIT_NVM;
					if (silent || (bcast && (exc != EXC_NONE || r_func != FC_WRITE))) begin
						state <= S_IDLE;
					end else if (exc != EXC_NONE || r_func == FC_LOOP) begin
						state <= S_RESP;
					end else begin
						state <= (r_func == FC_WRITE) ? S_WRITE : S_READ;
					end
				end
				S_WRITE, S_READ, S_COMMIT: begin
					pend <= 16'(cnt) < copy_n;
					cnt_d <= cnt;
					if (16'(cnt) < copy_n) begin
						cnt <= cnt + 6'h01;
					end else if (!pend) begin
						cnt <= '0;
						if (state == S_WRITE && is_commit) begin
							state <= S_COMMIT;
						end else begin
							state <= (bcast && state != S_READ) ? S_IDLE : S_RESP;
						end
					end
				end
				S_RESP: if (tx_valid && tx_ready && tx_last) begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ==========
	// broadcast data and commit side effects
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{op_raw, speed_ref, op_word, freq_out, hold_w} <= '0;
			{nvm_write_req, nvm_pending} <= '0;
		end else begin
			if (state == S_WRITE && pend && t_wr == ADDR_OP) begin
				op_raw <= buf_if.rd_data;
			end
			if (state == S_WRITE && pend && t_wr == ADDR_REF) begin
				speed_ref <= buf_if.rd_data;
			end
			hold_w <= (t_iss == ADDR_OP) ? op_raw : (t_iss == ADDR_REF) ? speed_ref : 16'h0000;
			op_word <= (op_raw & ~LOCAL_MASK) | (local_op & LOCAL_MASK);
			freq_out <= 16'((32'(speed_ref) * 32'(FMAX_UNITS)) / 32'(SPEED_FULL));
			nvm_write_req <= state == S_COMMIT && !pend && 16'(cnt) == copy_n && nvm_sel;
			if (nvm_write_req) begin
				nvm_pending <= 1'b1;
			end else if (nvm_done) begin
				nvm_pending <= 1'b0;
			end
		end
	end

	assign run_cmd             = op_word[OPB_RUN];
	assign reverse_cmd         = op_word[OPB_REV];
	assign ext_fault           = op_word[OPB_EXTF];
	assign fault_reset         = op_word[OPB_FRST];
	assign digital_input_five  = op_word[OPB_DI];
	assign digital_input_six   = op_word[OPB_DI + 1];
	assign digital_input_seven = op_word[OPB_DI + 2];
	assign digital_input_eight = op_word[OPB_DI + 3];
	assign param_rd_data       = act_if.rd_data;

	// ==========
	// transmit and self test
	assign st_if.ack      = test_mode && tx_valid && tx_ready;
	assign st_if.rx_valid = test_mode && rx_valid;
	assign st_if.rx_byte  = rx_byte;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{tx_valid, tx_last, fetched} <= '0;
			tx_data <= 8'h00;
			tx_idx <= '0;
			{test_mode, test_pass, comm_error_alarm, error_contact, op_ready} <= '0;
		end else begin
			test_mode <= input_function_select_fifth == TEST_MODE_CODE;
			test_pass <= st_if.pass;
			comm_error_alarm <= st_if.fail;
			error_contact <= st_if.fail;
			op_ready <= !st_if.fail && !test_mode;
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
				fetched <= 1'b0;
				tx_idx <= test_mode ? tx_idx : tx_idx + 6'h01;
			end else if (test_mode) begin
				if (st_if.req) begin
					tx_valid <= 1'b1;
					tx_data <= st_if.byte_out;
					tx_last <= 1'b1;
				end
			end else if (state == S_RESP) begin
				// one idle cycle per byte lets the buffer read settle
				if (fetched) begin
					tx_valid <= 1'b1;
					tx_data <= resp_byte;
					tx_last <= tx_idx == resp_len - 6'h01;
				end
				fetched <= 1'b1;
			end else begin
				tx_idx <= '0;
				fetched <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/reply_checker.sv]
// assertions on the handler's ports
// assumes a bind into slave_cmd_handler, one clock
`timescale 1ns/100ps
`default_nettype none
module reply_checker import slave_cmd_pkg::*; #(
	parameter logic [15:0] FMAX_UNITS = 16'h1770
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_last,
	input wire logic [15:0] op_word,
	input wire logic [15:0] local_op,
	input wire logic [15:0] speed_ref,
	input wire logic [15:0] freq_out,
	input wire logic        nvm_write_req,
	input wire logic        test_pass,
	input wire logic        comm_error_alarm,
	input wire logic        error_contact,
	input wire logic        op_ready,
	input wire logic [7:0]  input_function_select_fifth
);
	// ==========
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("reply byte not held");
	a_local_bits: assert property (
		!$past(sys_rst) |-> (op_word & LOCAL_MASK) == ($past(local_op) & LOCAL_MASK))
		else $error("local op bits wrong");
	a_nvm_pulse: assert property (nvm_write_req |=> !nvm_write_req)
		else $error("store request too long");
	a_freq_scale: assert property (
		$stable(speed_ref)[*8] |-> 32'(freq_out) == 32'(speed_ref) * 32'(FMAX_UNITS) / 30000)
		else $error("frequency scale wrong");
	a_test_fail: assert property (
		comm_error_alarm ##1 comm_error_alarm |-> error_contact && !op_ready)
		else $error("self test failure outputs wrong");
	a_alarm_keep: assert property (comm_error_alarm |=> comm_error_alarm)
		else $error("alarm dropped without reset");
	a_pass_excl: assert property (!(test_pass && comm_error_alarm))
		else $error("pass and alarm together");
	a_ready_mode: assert property (
		(input_function_select_fifth != TEST_MODE_CODE && !comm_error_alarm)[*4] |-> op_ready)
		else $error("ready low outside test mode");
endmodule

bind slave_cmd_handler reply_checker #(.FMAX_UNITS(FMAX_UNITS)) checker_i (
	.clk, .sys_rst, .tx_valid, .tx_ready, .tx_data, .tx_last, .op_word, .local_op,
	.speed_ref, .freq_out, .nvm_write_req, .test_pass, .comm_error_alarm,
	.error_contact, .op_ready, .input_function_select_fifth);
`default_nettype wire

// [bench/plc_master.sv]
// master model: sends requests, collects replies
// assumes bytes go out deframed, CRC already handled
`timescale 1ns/100ps
`default_nettype none
module plc_master (
	input wire logic        clk,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_end,
	output logic            rx_err,
	output logic            tx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_last
);
	logic [7:0] got [$];
	int         lastn;
	initial begin
		{rx_valid, rx_byte, rx_end, rx_err, tx_ready} = '0;
	end
	// stalls every other cycle: slave must hold its byte
	always @(posedge clk) begin
		tx_ready <= ~tx_ready;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (tx_last) lastn = got.size();
		end
	end
	// line shows inverse data between bytes
	task automatic send(input logic [87:0] q, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_byte <= q[8*i+:8];
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_byte <= ~q[8*i+:8];
		end
		@(posedge clk);
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// bench for the slave command handler
// assumes the master model paces replies and stays silent in self test
`timescale 1ns/100ps
`default_nettype none
module tb import slave_cmd_pkg::*;;
	localparam logic [15:0] FMAX = 16'h1770;
	typedef struct {logic [3:0] c; int n; logic [87:0] q; int m; logic [47:0] r;} row_s;
	logic        clk = 1'b0, sys_rst = 1'b1, nvm_done = 1'b0, proc_busy = 1'b0;
	logic        motor_running = 1'b0, undervoltage_alarm = 1'b0, nvm_defect_alarm = 1'b0;
	logic [15:0] local_op = 16'h0A88;
	logic [7:0]  input_function_select_fifth = 8'h00;
	logic [7:0]  rx_byte, tx_data;
	logic [15:0] op_word, speed_ref, freq_out, param_rd_data;
	logic        rx_valid, rx_end, rx_err, tx_ready, tx_valid, tx_last, nvm_write_req;
	logic        run_cmd, reverse_cmd, ext_fault, fault_reset, test_pass;
	logic        digital_input_five, digital_input_six, digital_input_seven;
	logic        digital_input_eight, comm_error_alarm, error_contact, op_ready;
	int          failures = 0, cmp_count = 0, nvm_n = 0;
	row_s rows [14] = '{
		'{4'h0, 6, 88'h010400010001, 3, 48'h018401},
		'{4'h0, 6, 88'h010309000001, 3, 48'h018302},
		'{4'h0, 6, 88'h010300010000, 3, 48'h018303},
		'{4'h0, 6, 88'h010300010011, 3, 48'h018303},
		'{4'h0, 11, 88'h0110010000010400050000, 3, 48'h019003},
		'{4'h0, 9, 88'h011000200001020001, 3, 48'h019022},
		'{4'h2, 9, 88'h011001050001020007, 3, 48'h019022},
		'{4'h1, 9, 88'h011001000001020007, 3, 48'h019022},
		'{4'h4, 9, 88'h011001000001020007, 3, 48'h019023},
		'{4'h8, 9, 88'h011001000001020007, 3, 48'h019024},
		'{4'h0, 9, 88'h011000020001027531, 3, 48'h019021},
		'{4'h0, 9, 88'h011000020001027530, 6, 48'h011000020001},
		'{4'h0, 9, 88'h021001000001020007, 0, 48'h0},
		'{4'h0, 9, 88'h01100001000102F033, 6, 48'h011000010001}};
	slave_cmd_handler #(.GAP_CYCLES(200), .FMAX_UNITS(FMAX), .ST_TIMEOUT(100)) dut (
		.clk, .sys_rst, .rx_valid, .rx_byte, .rx_end, .rx_err, .tx_ready, .motor_running,
		.undervoltage_alarm, .nvm_defect_alarm, .proc_busy, .nvm_done, .local_op,
		.input_function_select_fifth, .param_rd_addr(4'h0), .tx_valid, .tx_data, .tx_last,
		.op_word, .run_cmd, .reverse_cmd, .ext_fault, .fault_reset, .digital_input_five,
		.digital_input_six, .digital_input_seven, .digital_input_eight, .speed_ref,
		.freq_out, .param_rd_data, .nvm_write_req, .test_pass, .comm_error_alarm,
		.error_contact, .op_ready);
	plc_master mst (.clk, .rx_valid, .rx_byte, .rx_end, .rx_err, .tx_ready, .tx_valid,
		.tx_data, .tx_last);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		nvm_done <= nvm_write_req;
		if (nvm_write_req) nvm_n++;
	end
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic run(input logic [3:0] c, input int n, input logic [87:0] q, input int m,
		input logic [47:0] r);
		logic [47:0] v;
		{proc_busy, undervoltage_alarm, nvm_defect_alarm, motor_running} <= c;
		mst.got.delete();
		mst.lastn = 0;
		for (int t = 0; t < 2 && mst.got.size() == 0; t++) begin
			mst.send(q, n);
			repeat (400) if (m == 0 || mst.got.size() < m) @(posedge clk);
		end
		v = '0;
		foreach (mst.got[i]) v = {v[39:0], mst.got[i]};
		chk("reply", r, v);
		chk("length", m, mst.got.size());
		chk("last", m, mst.lastn);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		results();
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) run(rows[i].c, rows[i].n, rows[i].q, rows[i].m, rows[i].r);
		chk("op", 16'hFABB, op_word);
		chk("fields", 8'hFF, {digital_input_eight, digital_input_seven, digital_input_six,
			digital_input_five, fault_reset, ext_fault, reverse_cmd, run_cmd});
		chk("freq", FMAX, freq_out);
		run(4'h0, 9, 88'h001000010001020002, 0, 48'h0);
		chk("bcast", 16'h0A8A, op_word);
		run(4'h0, 9, 88'h011001000001020005, 6, 48'h011001000001);
		run(4'h0, 9, 88'h011009100001020000, 6, 48'h011009100001);
		chk("ram", 16'h0005, param_rd_data);
		chk("nvm", 0, nvm_n);
		run(4'h0, 9, 88'h011001000001020006, 6, 48'h011001000001);
		chk("staged", 16'h0005, param_rd_data);
		run(4'h0, 9, 88'h011009000001020000, 6, 48'h011009000001);
		chk("stored", 16'h0006, param_rd_data);
		chk("nvm", 1, nvm_n);
		// test mode is sampled from the select input each clock once reset is released
		sys_rst <= 1'b1;
		input_function_select_fifth <= TEST_MODE_CODE;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2000) if (comm_error_alarm !== 1'b1) @(posedge clk);
		chk("selftest", 3'b110, {comm_error_alarm, error_contact, op_ready});
		results();
	end
endmodule
`default_nettype wire
